//--- inc/spmc_pkg.sv
package spmc_pkg;
	// pin indices of port a
	localparam int unsigned PIN_COUNT      = 6;
	localparam int unsigned PIN_DEBUG      = 4;
	localparam int unsigned PIN_RESET      = 5;
	// reset values of control bits
	localparam logic [5:0]  PULLUP_RESET   = 6'h00;
	localparam logic [5:0]  SLEW_RESET     = 6'h3f;
	localparam logic [5:0]  DRIVE_RESET    = 6'h00;
	localparam logic [5:0]  DIR_RESET      = 6'h00;
	localparam logic        RSTPIN_RESET   = 1'b0;
	localparam logic        DBGPIN_RESET   = 1'b1;
	// mode select level that picks normal run mode
	localparam logic        MS_RUN_LEVEL   = 1'b1;
	// reset vector location (high byte address, low byte at +1)
	localparam logic [15:0] RESET_VECTOR_HI = 16'hfffe;
	localparam logic [15:0] RESET_VECTOR_LO = 16'hffff;
	// debug controller clocks per serial bit time
	localparam int unsigned DBG_CLKS_PER_BIT = 16;
	localparam logic [3:0]  DBG_BIT_LAST     = 4'hf;

	typedef enum logic [1:0] {
		SPMC_MODE_RUN = 2'b01,
		SPMC_MODE_BKG = 2'b10
	} spmc_mode_t;
endpackage

//--- rtl/spmc_bit_timer.sv
`timescale 1ns/100ps
// one-cycle tick at the end of each debug bit time
module spmc_bit_timer (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic run,
	output logic      bit_tick
);
	logic [3:0] count;
	wire        at_last = (count == spmc_pkg::DBG_BIT_LAST);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count    <= 4'h0;
			bit_tick <= 1'b0;
		end else begin
			count    <= run ? count + 4'h1 : 4'h0;
			bit_tick <= run && at_last;
		end
	end
endmodule

//--- rtl/spmc_pin_control.sv
`timescale 1ns/100ps
// How it works
// - after power-on into run mode the reset-capable pin is a plain input
// - setting reset_pin_enable makes the pin the reset input until power-on
// - with reset function on, a low pin requests a device reset
// - pullup always on while the pin acts as reset input
// - power-on into background mode makes the pin the reset input
// - timer two capture mode routes the pin to its capture input
// - debug pin is mode select in reset, debug line right after
// - debug_pin_enable sets on rstn but not on a debug-forced reset; software clears to free the pin
// - mode select high at reset release gives run, low gives background
// - a debug bit time lasts sixteen debug controller clocks
// - after reset non-output-only pins are inputs, pullups off
// - output-only pin starts disabled, low drive, slew limited
// - per-pin pullup, suppressed while the pin is driven as output
// - pullup also off while an analog function owns the pin
// - rising-edge keyboard or external interrupt turns pullup into pulldown
// - slew limit only acts while the pin is an output
// - drive select bit set gives high drive, clear gives low
// - highest-priority enabled function owns a shared pin
// - both analog modules enabled share the pin together
// - run mode starts at the vector fetched from the top of memory
// - background mode also entered by command, halt instruction, breakpoint
module spmc_pin_control (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        por,
	input  wire logic        debug_force_reset,
	// software control bits
	input  wire logic        reset_pin_enable_set,
	input  wire logic        debug_pin_enable_clear,
	input  wire logic [5:0]  pullup_enable_bits,
	input  wire logic [5:0]  slew_limit_bits,
	input  wire logic [5:0]  drive_select_bits,
	input  wire logic [5:0]  port_dir_out,
	input  wire logic        output_only_enable,
	// peripheral requests
	input  wire logic [5:0]  periph_out_en,
	input  wire logic [3:0]  keyboard_interrupt_en,
	input  wire logic [3:0]  keyboard_rising,
	input  wire logic        irq_enable,
	input  wire logic        irq_rising,
	input  wire logic [3:0]  timer_one_en,
	input  wire logic        timer_two_capture_mode,
	input  wire logic        timer_two_compare_en,
	input  wire logic [3:0]  adc_one_en,
	input  wire logic [3:0]  adc_two_en,
	// background entry and exit events, debug clock run
	input  wire logic        bkg_command,
	input  wire logic        bkg_halt_instr,
	input  wire logic        bkg_breakpoint,
	input  wire logic        bkg_exit,
	input  wire logic        debug_dbg_clk_run,
	// pin levels
	input  wire logic        debug_mode_select_pin,
	input  wire logic        port_a_bit_five,
	// outputs
	output logic             reset_pin_active,
	output logic             pin_reset_request,
	output logic             timer_two_capture_input,
	output logic             irq_pin_input,
	output logic             debug_pin_enable,
	output logic             debug_line_active,
	output logic             mode_select_phase,
	output spmc_pkg::spmc_mode_t mode,
	output logic [15:0]      fetch_vector_addr,
	output logic             fetch_vector,
	output logic [5:0]       pullup_on,
	output logic [5:0]       pulldown_on,
	output logic [5:0]       slew_on,
	output logic [5:0]       high_drive_on,
	output logic [5:0]       pin_out_en,
	output logic [5:0]       analog_on,
	output logic [5:0]       keyboard_owns,
	output logic [5:0]       timer_owns,
	output logic             dbg_bit_tick
);
	// =====================================================
	// helpers
	// =====================================================
	function automatic logic [5:0] widen4(input logic [3:0] v);
		widen4 = {2'b00, v};
	endfunction

	// one-hot mask for a single pin of port a
	function automatic logic [5:0] pin_mask(
		input int unsigned idx,
		input logic        on
	);
		pin_mask      = 6'h00;
		pin_mask[idx] = on;
	endfunction

	// a function sees the pin level only while it owns the pin
	function automatic logic route(input logic owns, input logic level);
		route = owns ? level : 1'b0;
	endfunction

	// =====================================================
	// reset pin function and mode
	// =====================================================
	logic        reset_pin_latch;
	logic        reset_phase;
	logic        dbg_en;
	spmc_pkg::spmc_mode_t cur_mode;
	spmc_pkg::spmc_mode_t next_mode;

	// mode select is sampled at release of rstn, por or a debug-forced reset
	wire sel_reset  = por || debug_force_reset;
	wire ms_run     = (debug_mode_select_pin == spmc_pkg::MS_RUN_LEVEL);
	wire bkg_event  = bkg_command || bkg_halt_instr || bkg_breakpoint;
	// pin becomes reset input by software or by entering background at reset release
	wire rst_fn     = reset_pin_latch;

	always_comb begin
		next_mode = cur_mode;
		case (cur_mode)
			spmc_pkg::SPMC_MODE_RUN: begin
				if (bkg_event)
					next_mode = spmc_pkg::SPMC_MODE_BKG;
			end
			spmc_pkg::SPMC_MODE_BKG: begin
				if (bkg_exit)
					next_mode = spmc_pkg::SPMC_MODE_RUN;
			end
			default: next_mode = spmc_pkg::SPMC_MODE_RUN;
		endcase
		if (reset_phase && !sel_reset)
			next_mode = ms_run ? spmc_pkg::SPMC_MODE_RUN
			                   : spmc_pkg::SPMC_MODE_BKG;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_phase <= 1'b1;
			cur_mode    <= spmc_pkg::SPMC_MODE_RUN;
		end else begin
			reset_phase <= sel_reset;
			cur_mode    <= next_mode;
		end
	end

	// the latch survives every reset but por, so rstn does not clear it
	always_ff @(posedge clk) begin
		if (por)
			reset_pin_latch <= spmc_pkg::RSTPIN_RESET;
		else if (reset_phase && !sel_reset && !ms_run && !reset_pin_latch)
			reset_pin_latch <= 1'b1;
		else if (reset_pin_enable_set)
			reset_pin_latch <= 1'b1;
	end

	// the output follows the next value so a clear shows one cycle later
	wire next_dbg_en = dbg_en && !debug_pin_enable_clear;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			dbg_en <= spmc_pkg::DBGPIN_RESET;
		else
			dbg_en <= next_dbg_en;
	end

	// =====================================================
	// priority and ownership
	// =====================================================
	wire [5:0] reset_mask = pin_mask(spmc_pkg::PIN_RESET, rst_fn);
	wire [5:0] debug_mask = pin_mask(spmc_pkg::PIN_DEBUG, dbg_en);
	wire [5:0] irq_mask   = pin_mask(spmc_pkg::PIN_RESET, irq_enable);
	wire [5:0] cap_mask   = pin_mask(spmc_pkg::PIN_RESET,
	                                 timer_two_capture_mode);
	wire [5:0] cmp_mask   = pin_mask(spmc_pkg::PIN_DEBUG,
	                                 timer_two_compare_en);
	wire [5:0] oo_mask    = pin_mask(spmc_pkg::PIN_DEBUG,
	                                 output_only_enable);
	// pin five is never a port output, so its direction bit is ignored
	wire [5:0] in_only    = pin_mask(spmc_pkg::PIN_RESET, 1'b1);
	wire [5:0] analog_one = widen4(adc_one_en);
	wire [5:0] analog_two = widen4(adc_two_en);
	// both converters may hold one pin; neither locks out the other
	wire [5:0] analog_any = analog_one | analog_two;
	wire [5:0] kbi_req    = widen4(keyboard_interrupt_en);
	wire [5:0] tmr_req    = widen4(timer_one_en) | cmp_mask | cap_mask;
	// debug on pin four, irq and reset on pin five outrank the rest
	wire [5:0] sys_owns   = irq_mask | reset_mask | debug_mask;
	wire [5:0] hi_owns    = analog_any | sys_owns;
	wire [5:0] tmr_owns   = tmr_req & ~hi_owns;
	wire [5:0] kbi_owns   = kbi_req & ~tmr_req & ~hi_owns;
	wire [5:0] port_owns  = ~(hi_owns | tmr_owns | kbi_owns);
	wire [5:0] port_out   = port_owns & (port_dir_out | oo_mask)
	                        & ~in_only;
	wire [5:0] periph_out = (tmr_owns | kbi_owns) & periph_out_en;
	wire [5:0] out_dir    = port_out | periph_out;

	// =====================================================
	// pull devices, slew and drive
	// =====================================================
	wire [5:0] kbi_rising = widen4(keyboard_rising & keyboard_interrupt_en);
	wire [5:0] irq_rise   = pin_mask(spmc_pkg::PIN_RESET,
	                                 irq_enable & irq_rising & ~rst_fn);
	wire [5:0] rising     = kbi_rising | irq_rise;
	// pullup suppressed for outputs and analog, forced for reset function
	wire [5:0] pull_quiet = out_dir | analog_any | reset_mask;
	wire [5:0] pull_base  = pullup_enable_bits & ~pull_quiet;
	wire [5:0] pull_auto  = reset_mask | debug_mask;
	wire [5:0] next_pu    = (pull_base & ~rising) | pull_auto;
	wire [5:0] next_pd    = pull_base & rising;
	// slew and drive bits only reach the pad while it drives
	wire [5:0] next_slew  = slew_limit_bits & out_dir;
	wire [5:0] next_drive = drive_select_bits & out_dir;

	// =====================================================
	// pin five routing, reset request and vector
	// =====================================================
	// reset outranks irq, irq outranks the capture input
	wire cap_route   = timer_two_capture_mode && !rst_fn && !irq_enable;
	wire irq_route   = irq_enable && !rst_fn;
	wire next_cap_in = route(cap_route, port_a_bit_five);
	wire next_irq_in = route(irq_route, port_a_bit_five);
	// pin low with reset function on asks the system for a reset
	wire next_pin_rq = rst_fn && !port_a_bit_five;
	wire select_ends = reset_phase && !sel_reset;
	wire next_fetch  = select_ends && ms_run;
	// high byte of the vector first, low byte on the following cycle
	wire [15:0] next_addr = next_fetch ? spmc_pkg::RESET_VECTOR_HI
	                      : fetch_vector ? spmc_pkg::RESET_VECTOR_LO
	                      : fetch_vector_addr;

	// =====================================================
	// registered outputs
	// =====================================================
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pullup_on     <= spmc_pkg::PULLUP_RESET;
			pulldown_on   <= spmc_pkg::PULLUP_RESET;
		end else begin
			pullup_on     <= next_pu;
			pulldown_on   <= next_pd;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			pin_out_en    <= spmc_pkg::DIR_RESET;
		else
			pin_out_en    <= out_dir;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slew_on       <= spmc_pkg::SLEW_RESET;
			high_drive_on <= spmc_pkg::DRIVE_RESET;
		end else begin
			slew_on       <= next_slew;
			high_drive_on <= next_drive;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			analog_on     <= 6'h00;
		else
			analog_on     <= analog_any;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			keyboard_owns <= 6'h00;
			timer_owns    <= 6'h00;
		end else begin
			keyboard_owns <= kbi_owns;
			timer_owns    <= tmr_owns;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_pin_active  <= 1'b0;
			pin_reset_request <= 1'b0;
		end else begin
			reset_pin_active  <= rst_fn;
			pin_reset_request <= next_pin_rq;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timer_two_capture_input <= 1'b0;
			irq_pin_input           <= 1'b0;
		end else begin
			timer_two_capture_input <= next_cap_in;
			irq_pin_input           <= next_irq_in;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			debug_pin_enable  <= spmc_pkg::DBGPIN_RESET;
			debug_line_active <= 1'b0;
		end else begin
			debug_pin_enable  <= next_dbg_en;
			debug_line_active <= dbg_en && !reset_phase;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_select_phase <= 1'b1;
			mode              <= spmc_pkg::SPMC_MODE_RUN;
		end else begin
			mode_select_phase <= reset_phase;
			mode              <= next_mode;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			fetch_vector      <= 1'b0;
		else
			fetch_vector      <= next_fetch;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			fetch_vector_addr <= 16'h0000;
		else
			fetch_vector_addr <= next_addr;
	end

	// =====================================================
	// debug bit timing
	// =====================================================
	// bit timing stops once software frees the debug pin
	wire timer_run = debug_dbg_clk_run && dbg_en;

	spmc_bit_timer u_bit_timer (
		.clk      (clk),
		.rstn     (rstn),
		.run      (timer_run),
		.bit_tick (dbg_bit_tick)
	);
endmodule

//--- testbench/spmc_chk.sv
`timescale 1ns/100ps
// ==========
// checker on the pin control ports
module spmc_chk (
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire logic                 por,
	input wire logic                 debug_force_reset,
	input wire logic                 debug_pin_enable_clear,
	input wire logic                 debug_mode_select_pin,
	input wire logic                 port_a_bit_five,
	input wire logic                 reset_pin_active,
	input wire logic                 pin_reset_request,
	input wire logic                 debug_pin_enable,
	input wire logic                 mode_select_phase,
	input wire spmc_pkg::spmc_mode_t mode,
	input wire logic [15:0]          fetch_vector_addr,
	input wire logic                 fetch_vector,
	input wire logic [5:0]           pullup_on,
	input wire logic [5:0]           pulldown_on,
	input wire logic [5:0]           pin_out_en,
	input wire logic [5:0]           analog_on,
	input wire logic                 dbg_bit_tick
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// por guards: the latch may clear a cycle before its output drops
	a_pin_sticky: assert property (reset_pin_active && !por && !$past(por)
		|=> reset_pin_active) else $error("reset pin function dropped");
	a_pin_pullup: assert property (reset_pin_active && $past(reset_pin_active)
		|-> pullup_on[5]) else $error("no pullup on reset pin");
	a_pin_reset: assert property (reset_pin_active && !port_a_bit_five &&
		!por && !$past(por) |=> pin_reset_request) else $error("no reset request");
	a_dbg_clear: assert property (debug_pin_enable_clear
		|=> !debug_pin_enable) else $error("debug pin enable not cleared");
	a_mode_pick: assert property (mode_select_phase && !por &&
		!debug_force_reset |=> mode == ((debug_mode_select_pin ==
		spmc_pkg::MS_RUN_LEVEL) ? spmc_pkg::SPMC_MODE_RUN :
		spmc_pkg::SPMC_MODE_BKG)) else $error("wrong mode at reset release");
	a_vector_addr: assert property (fetch_vector |->
		fetch_vector_addr == spmc_pkg::RESET_VECTOR_HI &&
		mode == spmc_pkg::SPMC_MODE_RUN) else $error("bad vector fetch");
	a_pull_output: assert property ((pullup_on & pin_out_en) == 6'h00)
		else $error("pullup on output pin");
	a_pull_analog: assert property ((pullup_on & analog_on) == 6'h00)
		else $error("pullup on analog pin");
	a_pull_swap: assert property ((pullup_on & pulldown_on) == 6'h00)
		else $error("pullup and pulldown together");
	a_tick_space: assert property (dbg_bit_tick |=> !dbg_bit_tick [*8])
		else $error("debug bit ticks too close");
endmodule
bind spmc_pin_control spmc_chk u_chk (.*);

//--- testbench/spmc_host.sv
`timescale 1ns/100ps
// ==========
// reset source and debug host
module spmc_host (
	input  wire logic hold_ms_low,
	input  wire logic pull_reset_low,
	output logic      debug_mode_select_pin,
	output logic      port_a_bit_five
);
	// both sources drive actively, so no floating level is modelled
	assign debug_mode_select_pin = !hold_ms_low;
	assign port_a_bit_five       = !pull_reset_low;
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
// ==========
// bench for the pin control block
module tb;
	logic clk, rstn, por, debug_force_reset, reset_pin_enable_set;
	logic debug_pin_enable_clear, output_only_enable, irq_enable, irq_rising;
	logic timer_two_capture_mode, timer_two_compare_en, bkg_command;
	logic bkg_halt_instr, bkg_breakpoint, bkg_exit, debug_dbg_clk_run;
	logic hold_ms_low, pull_reset_low, debug_mode_select_pin, port_a_bit_five;
	logic [5:0] pullup_enable_bits, slew_limit_bits, drive_select_bits;
	logic [5:0] port_dir_out, periph_out_en;
	logic [3:0] keyboard_interrupt_en, keyboard_rising, timer_one_en;
	logic [3:0] adc_one_en, adc_two_en;
	logic reset_pin_active, pin_reset_request, timer_two_capture_input;
	logic irq_pin_input, debug_pin_enable, debug_line_active;
	logic mode_select_phase, fetch_vector, dbg_bit_tick;
	spmc_pkg::spmc_mode_t mode;
	logic [15:0] fetch_vector_addr;
	logic [5:0] pullup_on, pulldown_on, slew_on, high_drive_on, pin_out_en;
	logic [5:0] analog_on, keyboard_owns, timer_owns;
	int error_cnt = 0;
	int samples_checked = 0;
	int n;
	spmc_pin_control DUT (.*);
	spmc_host u_host (.*);
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		tick(1);
		s = 1'h0;
		tick(2);
	endtask
	// power-on with the host holding mode select as asked
	task automatic boot(input logic ms_low, input logic [15:0] vec);
		logic seen;
		seen = 1'h0;
		hold_ms_low = ms_low;
		rstn = 1'h0;
		por = 1'h1;
		tick(20);
		rstn = 1'h1;
		tick(1);
		por = 1'h0;
		for (int i = 0; i < 6; i++) begin
			tick(1);
			seen |= fetch_vector;
		end
		hold_ms_low = 1'h0;
		chk(seen, vec);
	endtask
	task automatic wait_tick(output int c);
		c = 0;
		do begin
			tick(1);
			c++;
		end while (dbg_bit_tick !== 1'b1 && c < 40);
		if (dbg_bit_tick !== 1'b1) begin
			chk(c, 16'h0);
			wrap_up();
		end
	endtask
	task automatic ev(ref logic s);
		pulse(bkg_exit);
		chk(mode, spmc_pkg::SPMC_MODE_RUN);
		pulse(s);
		chk(mode, spmc_pkg::SPMC_MODE_BKG);
	endtask
	initial begin
		{rstn, por, debug_force_reset, reset_pin_enable_set,
		 debug_pin_enable_clear, output_only_enable, irq_enable, irq_rising,
		 timer_two_capture_mode, timer_two_compare_en, bkg_command,
		 bkg_halt_instr, bkg_breakpoint, bkg_exit, debug_dbg_clk_run,
		 hold_ms_low, pull_reset_low, pullup_enable_bits, slew_limit_bits,
		 drive_select_bits, port_dir_out, periph_out_en, timer_one_en,
		 keyboard_interrupt_en, keyboard_rising, adc_one_en, adc_two_en} = '0;
		boot(1'h0, 16'h1);
		chk(mode, spmc_pkg::SPMC_MODE_RUN);
		chk({reset_pin_active, debug_pin_enable}, 2'h1);
		chk(debug_line_active, 1'h1);
		chk({pullup_on, pin_out_en}, 12'h400);
		chk({high_drive_on, slew_on}, 12'h000);
		pullup_enable_bits = 6'h0f;
		tick(2);
		chk(pullup_on[3:0], 4'hf);
		{slew_limit_bits, drive_select_bits, port_dir_out} = 18'h3f_041;
		{adc_one_en, adc_two_en, keyboard_interrupt_en} = 12'h22c;
		{keyboard_rising, timer_one_en} = 8'h48;
		tick(2);
		chk(pullup_on[2:0], 3'h0);
		chk({pulldown_on[2], analog_on[1]}, 2'h3);
		chk({slew_on[2:0], high_drive_on[0]}, 4'h3);
		chk({timer_owns[3], keyboard_owns[3]}, 2'h2);
		timer_two_capture_mode = 1'h1;
		pull_reset_low = 1'h1;
		tick(2);
		chk(timer_two_capture_input, 1'h0);
		pull_reset_low = 1'h0;
		tick(2);
		chk(timer_two_capture_input, 1'h1);
		irq_enable = 1'h1;
		tick(2);
		chk({irq_pin_input, timer_two_capture_input}, 2'h2);
		irq_enable = 1'h0;
		pulse(reset_pin_enable_set);
		chk({reset_pin_active, pullup_on[5]}, 2'h3);
		pull_reset_low = 1'h1;
		tick(2);
		chk(pin_reset_request, 1'h1);
		pull_reset_low = 1'h0;
		pulse(debug_pin_enable_clear);
		chk(debug_pin_enable, 1'h0);
		rstn = 1'h0;
		tick(2);
		rstn = 1'h1;
		tick(3);
		chk({reset_pin_active, debug_pin_enable}, 2'h3);
		boot(1'h1, 16'h0);
		chk(mode, spmc_pkg::SPMC_MODE_BKG);
		chk(reset_pin_active, 1'h1);
		ev(bkg_command);
		ev(bkg_halt_instr);
		ev(bkg_breakpoint);
		boot(1'h0, 16'h1);
		chk(reset_pin_active, 1'h0);
		hold_ms_low = 1'h1;
		debug_force_reset = 1'h1;
		tick(2);
		debug_force_reset = 1'h0;
		tick(3);
		hold_ms_low = 1'h0;
		chk(mode, spmc_pkg::SPMC_MODE_BKG);
		debug_dbg_clk_run = 1'h1;
		wait_tick(n);
		wait_tick(n);
		chk(n, 16'h10);
		wrap_up();
	end
endmodule
